// file: rtl/urg_pkg.sv
/*
 * Shared constants of the UART rate generator: register map, field
 * positions, reset values, divider figures and source codes.
 * Assumes a byte-wide register port with a small word address.
 */
package urg_pkg;

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   localparam logic [3:0] ADDR_RATE_GEN_CONTROL  = 4'h0;
   localparam logic [3:0] ADDR_RATE_GEN_FRACTION = 4'h1;
   localparam logic [3:0] ADDR_GEN_TIMER_CONTROL = 4'h2;
   localparam logic [3:0] ADDR_RELOAD_LOW_BYTE   = 4'h3;
   localparam logic [3:0] ADDR_RELOAD_HIGH_BYTE  = 4'h4;
   localparam logic [3:0] ADDR_POWER_CONTROL     = 4'h5;
   localparam logic [3:0] ADDR_PLL_CONTROL       = 4'h6;
   localparam logic [3:0] ADDR_SOURCE_STATUS     = 4'h7;
   localparam logic [3:0] ADDR_GEN_COUNT_LOW     = 4'h8;
   localparam logic [3:0] ADDR_GEN_COUNT_HIGH    = 4'h9;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int DED_EN_BIT   = 7;
   localparam int DIV_LSB      = 0;
   localparam int DIV_W        = 3;
   localparam int RX_SEL_BIT   = 5;
   localparam int TX_SEL_BIT   = 4;
   localparam int GEN_RUN_BIT  = 2;
   localparam int DOUBLING_BIT = 7;
   localparam int CORE_DIV_LSB = 0;
   localparam int CORE_DIV_W   = 3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  RST_CONTROL  = 8'h00;
   localparam logic [7:0]  RST_FRACTION = 8'h00;
   localparam logic [15:0] RST_RELOAD   = 16'h0000;
   localparam logic [2:0]  RST_CORE_DIV = 3'h0;

   // ----------------------------------------------------------------
   // Divider figures
   // ----------------------------------------------------------------
   localparam int          OS_PER_BIT   = 16;
   localparam int          OS_CNT_W     = 4;
   localparam int          PRE_W        = 7;
   localparam int          ACC_W        = 9;
   localparam logic [9:0]  FRAC_BASE    = 10'h040;
   localparam logic [9:0]  FRAC_STEP    = 10'h020;
   localparam logic [15:0] GEN_TOP      = 16'hFFFF;
   localparam logic [1:0]  FIX_OS_SLOW  = 2'h3;
   localparam logic [1:0]  FIX_OS_FAST  = 2'h1;

   // ----------------------------------------------------------------
   // UART modes and source codes
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_SHIFT     = 2'h0;
   localparam logic [1:0] MODE_VAR_8BIT  = 2'h1;
   localparam logic [1:0] MODE_FIXED_9   = 2'h2;
   localparam logic [1:0] MODE_VAR_9BIT  = 2'h3;

   localparam logic [1:0] SRC_NONE      = 2'h0;
   localparam logic [1:0] SRC_DEDICATED = 2'h1;
   localparam logic [1:0] SRC_GENERAL   = 2'h2;
   localparam logic [1:0] SRC_LEGACY    = 2'h3;

endpackage

// file: rtl/urg_tick_div.sv
/*
 * Modulo counter of step pulses: flags the step that completes each
 * group of MODULUS steps.
 * Assumes one clock, synchronous active-low reset, one-cycle steps.
 */
`timescale 1ns/1ns
module urg_tick_div #(
   parameter int CNT_W   = 4,
   parameter int MODULUS = 16
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_resetn,
   // Steps in, group end out
   input  wire logic i_step,
   output logic      o_wrap
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } urg_div_state_t;

   localparam logic [CNT_W-1:0] LAST = CNT_W'(MODULUS - 1);

   urg_div_state_t st_reg;
   urg_div_state_t st_next;

   always_comb begin
      st_next = st_reg;
      o_wrap  = 1'b0;
      if (i_step) begin
         if (st_reg.cnt == LAST) begin
            st_next.cnt = '0;
            o_wrap      = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   group_end_a: assert property (
      o_wrap |=> st_reg.cnt == '0)
      else $error("Step group did not restart after its last step");

endmodule

// file: rtl/urg_rate_gen.sv
/*
 * UART rate generator: general 16-bit timer in rate mode, dedicated
 * prescaler plus fractional divider, legacy fixed and external-timer
 * paths, register port. Emits oversample and bit ticks per direction.
 * Assumes i_clk is the fast clock from which the core clock is made
 * by the core divider, and synchronous inputs.
 */
// What this block does
// - Bit advances after sixteen general timer overflows.
// - General timer steps every two core clocks.
// - Overflow reloads full 16-bit value.
// - Select bits pick general timer per direction in the variable modes.
// - Rate is core clock over 32 times counts.
// - Dedicated enable overrides doubling and select bits.
// - Dedicated disabled gives the legacy path to unselected directions.
// - Prescale core clock by two to exponent.
// - Rate is 2*core over prescale*(fraction+64).
// - Fraction lives in its own writable register.
// - Core clock chosen by three-bit core divider.
// - Covers 12 to 393216 bps within 0.8%.
// - Doubling bit doubles fixed and external-timer rates.
`timescale 1ns/1ns
module urg_rate_gen (
   // Clock and reset
   input  wire logic                       i_clk,
   input  wire logic                       i_resetn,
   // Register port
   input  wire logic [urg_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [urg_pkg::DATA_W-1:0] i_wdata,
   input  wire logic                       i_wr,
   input  wire logic                       i_rd,
   output logic      [urg_pkg::DATA_W-1:0] o_rdata,
   // UART side
   input  wire logic [1:0]                 i_uart_mode,
   input  wire logic                       i_t1_overflow,
   output logic                            o_tx_os_tick,
   output logic                            o_rx_os_tick,
   output logic                            o_tx_bit_tick,
   output logic                            o_rx_bit_tick
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [urg_pkg::PRE_W-1:0]      cd_cnt;
      logic [urg_pkg::PRE_W-1:0]      pre_cnt;
      logic [urg_pkg::ACC_W-1:0]      frac_acc;
      logic [15:0]                    gen_cnt;
      logic                           gen_phase;
      logic                           t1_half;
      logic [1:0]                     fix_cnt;
      logic                           ded_en;
      logic [urg_pkg::DIV_W-1:0]      div;
      logic [7:0]                     fraction;
      logic                           tx_sel;
      logic                           rx_sel;
      logic                           gen_run;
      logic [15:0]                    reload;
      logic                           doubling;
      logic [urg_pkg::CORE_DIV_W-1:0] core_div;
      logic [7:0]                     rdata;
      logic                           tx_os;
      logic                           rx_os;
      logic                           tx_bit;
      logic                           rx_bit;
   } urg_state_t;

   urg_state_t st_reg;
   urg_state_t st_next;

   logic       core_tick;
   logic       pre_tick;
   logic       ded_os;
   logic       gen_step;
   logic       gen_on;
   logic       gen_ovf;
   logic       t1_os;
   logic       fix_os;
   logic       var_mode;
   logic       tx_os_c;
   logic       rx_os_c;
   logic       tx_wrap;
   logic       rx_wrap;
   logic [1:0] tx_src;
   logic [1:0] rx_src;
   logic [7:0] cd_pow;
   logic [7:0] pre_pow;
   logic [6:0] cd_mask;
   logic [6:0] pre_mask;
   logic [9:0] acc_sum;
   logic [9:0] acc_lim;

   // ----------------------------------------------------------------
   // Bit dividers, one per direction
   // ----------------------------------------------------------------
   urg_tick_div #(
      .CNT_W   (urg_pkg::OS_CNT_W),
      .MODULUS (urg_pkg::OS_PER_BIT)
   ) u_tx_div (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_step   (tx_os_c),
      .o_wrap   (tx_wrap)
   );

   urg_tick_div #(
      .CNT_W   (urg_pkg::OS_CNT_W),
      .MODULUS (urg_pkg::OS_PER_BIT)
   ) u_rx_div (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_step   (rx_os_c),
      .o_wrap   (rx_wrap)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      // core clock from the core divider
      cd_pow    = 8'h01 << st_reg.core_div;
      cd_mask   = 7'(cd_pow - 8'h01);
      core_tick = (st_reg.cd_cnt & cd_mask) == cd_mask;
      st_next.cd_cnt = st_reg.cd_cnt + 1'b1;

      // binary prescaler on the core clock
      pre_pow  = 8'h01 << st_reg.div;
      pre_mask = 7'(pre_pow - 8'h01);
      pre_tick = core_tick && ((st_reg.pre_cnt & pre_mask) == pre_mask);
      if (core_tick) begin
         st_next.pre_cnt = st_reg.pre_cnt + 1'b1;
      end

      // 32 per prescale tick against fraction+64 keeps rate exact
      acc_sum = {1'b0, st_reg.frac_acc} + urg_pkg::FRAC_STEP;
      acc_lim = {2'b00, st_reg.fraction} + urg_pkg::FRAC_BASE;
      ded_os  = 1'b0;
      if (pre_tick) begin
         // one oversample tick per completed fractional count
         if (acc_sum >= acc_lim) begin
            ded_os           = 1'b1;
            st_next.frac_acc = urg_pkg::ACC_W'(acc_sum - acc_lim);
            // A smaller fraction written mid-count leaves a stale
            // remainder above the new limit; restart it instead
            if ({1'b0, st_reg.frac_acc} >= acc_lim) begin
               st_next.frac_acc = '0;
            end
         end else begin
            st_next.frac_acc = urg_pkg::ACC_W'(acc_sum);
         end
      end

      // general timer steps on every second core clock
      gen_step = 1'b0;
      gen_ovf  = 1'b0;
      gen_on   = st_reg.gen_run && (st_reg.tx_sel || st_reg.rx_sel);
      if (gen_on) begin
         if (core_tick) begin
            st_next.gen_phase = !st_reg.gen_phase;
            gen_step          = st_reg.gen_phase;
         end
      end else begin
         // Stopped timer holds its reload, so a start needs no full lap
         st_next.gen_phase = 1'b0;
         st_next.gen_cnt   = st_reg.reload;
      end
      if (gen_step) begin
         if (st_reg.gen_cnt == urg_pkg::GEN_TOP) begin
            st_next.gen_cnt = st_reg.reload;
            gen_ovf         = 1'b1;
         end else begin
            st_next.gen_cnt = st_reg.gen_cnt + 1'b1;
         end
      end

      // doubling halves the external timer and fixed dividers
      if (i_t1_overflow) begin
         st_next.t1_half = !st_reg.t1_half;
      end
      t1_os  = i_t1_overflow && (st_reg.doubling || st_reg.t1_half);
      fix_os = 1'b0;
      if (core_tick) begin
         if (st_reg.fix_cnt == (st_reg.doubling ? urg_pkg::FIX_OS_FAST
                                                : urg_pkg::FIX_OS_SLOW))
         begin
            st_next.fix_cnt = 2'h0;
            fix_os          = 1'b1;
         end else begin
            st_next.fix_cnt = st_reg.fix_cnt + 1'b1;
         end
      end

      // Source choice per direction; shift mode has its own clock
      var_mode = (i_uart_mode == urg_pkg::MODE_VAR_8BIT) ||
                 (i_uart_mode == urg_pkg::MODE_VAR_9BIT);
      tx_src   = urg_pkg::SRC_NONE;
      rx_src   = urg_pkg::SRC_NONE;
      if (i_uart_mode != urg_pkg::MODE_SHIFT) begin
         // dedicated enable wins over doubling and selects
         if (st_reg.ded_en) begin
            tx_src = urg_pkg::SRC_DEDICATED;
            rx_src = urg_pkg::SRC_DEDICATED;
         end else if (var_mode) begin
            // each direction picks its own source
            tx_src = st_reg.tx_sel ? urg_pkg::SRC_GENERAL
                                   : urg_pkg::SRC_LEGACY;
            rx_src = st_reg.rx_sel ? urg_pkg::SRC_GENERAL
                                   : urg_pkg::SRC_LEGACY;
         end else begin
            // legacy fixed divider when dedicated is off
            tx_src = urg_pkg::SRC_LEGACY;
            rx_src = urg_pkg::SRC_LEGACY;
         end
      end
      // general overflow is one sixteenth of a bit
      case (tx_src)
         urg_pkg::SRC_DEDICATED: tx_os_c = ded_os;
         urg_pkg::SRC_GENERAL:   tx_os_c = gen_ovf;
         urg_pkg::SRC_LEGACY:    tx_os_c = var_mode ? t1_os : fix_os;
         default:                tx_os_c = 1'b0;
      endcase
      case (rx_src)
         urg_pkg::SRC_DEDICATED: rx_os_c = ded_os;
         urg_pkg::SRC_GENERAL:   rx_os_c = gen_ovf;
         urg_pkg::SRC_LEGACY:    rx_os_c = var_mode ? t1_os : fix_os;
         default:                rx_os_c = 1'b0;
      endcase
      st_next.tx_os  = tx_os_c;
      st_next.rx_os  = rx_os_c;
      st_next.tx_bit = tx_wrap;
      st_next.rx_bit = rx_wrap;

      if (i_wr) begin
         case (i_addr)
            urg_pkg::ADDR_RATE_GEN_CONTROL: begin
               st_next.ded_en = i_wdata[urg_pkg::DED_EN_BIT];
               st_next.div    = i_wdata[urg_pkg::DIV_LSB +:
                                        urg_pkg::DIV_W];
            end
            urg_pkg::ADDR_RATE_GEN_FRACTION: st_next.fraction = i_wdata;
            urg_pkg::ADDR_GEN_TIMER_CONTROL: begin
               st_next.rx_sel  = i_wdata[urg_pkg::RX_SEL_BIT];
               st_next.tx_sel  = i_wdata[urg_pkg::TX_SEL_BIT];
               st_next.gen_run = i_wdata[urg_pkg::GEN_RUN_BIT];
            end
            urg_pkg::ADDR_RELOAD_LOW_BYTE:  st_next.reload[7:0]  = i_wdata;
            urg_pkg::ADDR_RELOAD_HIGH_BYTE: st_next.reload[15:8] = i_wdata;
            urg_pkg::ADDR_POWER_CONTROL:
               st_next.doubling = i_wdata[urg_pkg::DOUBLING_BIT];
            urg_pkg::ADDR_PLL_CONTROL:
               st_next.core_div = i_wdata[urg_pkg::CORE_DIV_LSB +:
                                          urg_pkg::CORE_DIV_W];
            default: ;
         endcase
      end

      // Read data stands only in the cycle after the strobe
      st_next.rdata = 8'h00;
      if (i_rd) begin
         case (i_addr)
            urg_pkg::ADDR_RATE_GEN_CONTROL: begin
               st_next.rdata[urg_pkg::DED_EN_BIT] = st_reg.ded_en;
               st_next.rdata[urg_pkg::DIV_LSB +: urg_pkg::DIV_W] =
                  st_reg.div;
            end
            urg_pkg::ADDR_RATE_GEN_FRACTION: st_next.rdata = st_reg.fraction;
            urg_pkg::ADDR_GEN_TIMER_CONTROL: begin
               st_next.rdata[urg_pkg::RX_SEL_BIT]  = st_reg.rx_sel;
               st_next.rdata[urg_pkg::TX_SEL_BIT]  = st_reg.tx_sel;
               st_next.rdata[urg_pkg::GEN_RUN_BIT] = st_reg.gen_run;
            end
            urg_pkg::ADDR_RELOAD_LOW_BYTE:  st_next.rdata = st_reg.reload[7:0];
            urg_pkg::ADDR_RELOAD_HIGH_BYTE: st_next.rdata = st_reg.reload[15:8];
            urg_pkg::ADDR_POWER_CONTROL:
               st_next.rdata[urg_pkg::DOUBLING_BIT] = st_reg.doubling;
            urg_pkg::ADDR_PLL_CONTROL:
               st_next.rdata[urg_pkg::CORE_DIV_LSB +: urg_pkg::CORE_DIV_W] =
                  st_reg.core_div;
            urg_pkg::ADDR_SOURCE_STATUS: st_next.rdata = {4'h0, rx_src, tx_src};
            urg_pkg::ADDR_GEN_COUNT_LOW:  st_next.rdata = st_reg.gen_cnt[7:0];
            urg_pkg::ADDR_GEN_COUNT_HIGH: st_next.rdata = st_reg.gen_cnt[15:8];
            default: st_next.rdata = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         st_reg          <= '0;
         st_reg.ded_en   <= urg_pkg::RST_CONTROL[urg_pkg::DED_EN_BIT];
         st_reg.div      <= urg_pkg::RST_CONTROL[urg_pkg::DIV_LSB +:
                                                 urg_pkg::DIV_W];
         st_reg.fraction <= urg_pkg::RST_FRACTION;
         st_reg.reload   <= urg_pkg::RST_RELOAD;
         st_reg.core_div <= urg_pkg::RST_CORE_DIV;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_rdata       = st_reg.rdata;
   assign o_tx_os_tick  = st_reg.tx_os;
   assign o_rx_os_tick  = st_reg.rx_os;
   assign o_tx_bit_tick = st_reg.tx_bit;
   assign o_rx_bit_tick = st_reg.rx_bit;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   // bit tick only with an oversample tick
   tx_bit_align_a: assert property (
      o_tx_bit_tick |-> o_tx_os_tick)
      else $error("Transmit bit tick without oversample tick");
   gen_hold_a: assert property (
      !gen_step && gen_on |=> st_reg.gen_cnt == $past(st_reg.gen_cnt))
      else $error("General timer moved without a step");
   // two core clocks per general step
   gen_spacing_a: assert property (
      gen_step |-> !$past(gen_step))
      else $error("General timer stepped on adjacent core clocks");
   gen_reload_a: assert property (
      gen_step && st_reg.gen_cnt == urg_pkg::GEN_TOP
      |=> st_reg.gen_cnt == $past(st_reg.reload) && $past(gen_ovf))
      else $error("General timer reload wrong");
   // receive follows the general timer when selected
   rx_general_a: assert property (
      !st_reg.ded_en && var_mode && st_reg.rx_sel && gen_ovf
      |=> o_rx_os_tick)
      else $error("Receive tick missed general overflow");
   ded_override_a: assert property (
      st_reg.ded_en && i_uart_mode != urg_pkg::MODE_SHIFT && ded_os
      |=> o_tx_os_tick && o_rx_os_tick)
      else $error("Dedicated tick not delivered");
   // legacy external timer path when dedicated is off
   tx_legacy_a: assert property (
      !st_reg.ded_en && var_mode && !st_reg.tx_sel && t1_os
      |=> o_tx_os_tick)
      else $error("Legacy transmit tick missed");
   // undivided core clock ticks every cycle
   core_full_a: assert property (
      st_reg.core_div == 3'h0 |-> core_tick)
      else $error("Core tick missing at divider zero");
   doubling_a: assert property (
      st_reg.doubling && i_t1_overflow |-> t1_os)
      else $error("Doubling did not pass external overflow");
   // fractional accumulator stays below its limit after a tick
   frac_tick_a: assert property (
      ded_os |=> st_reg.frac_acc < $past(acc_lim))
      else $error("Fractional remainder out of range");

   ded_tick_c:  cover property (st_reg.ded_en && o_tx_bit_tick);
   gen_ovf_c:   cover property (gen_ovf ##[1:40] gen_ovf);
   rx_bit_c:    cover property (o_rx_bit_tick && !st_reg.ded_en);
   fix_mode_c:  cover property (i_uart_mode == urg_pkg::MODE_FIXED_9
                                && o_tx_os_tick);

endmodule

// file: dv/urg_uart_model.sv
/*
 * Partner model: bit timer of one UART direction. Times two bit
 * periods after a clear and counts the oversample ticks within them.
 * Assumes registered one-cycle ticks from the rate generator.
 */
`timescale 1ns/1ns
module urg_uart_model (
   // Clock and control
   input  wire logic   i_clk,
   input  wire logic   i_clear,
   // Ticks in
   input  wire logic   i_os,
   input  wire logic   i_bit,
   // Measurement out
   output logic        o_done,
   output logic [15:0] o_span,
   output logic [7:0]  o_os
);
   logic [1:0]  n = 2'h0;
   logic        armed = 1'b0;
   logic [15:0] cyc = 16'h0000;
   logic [7:0]  os = 8'h00;

   // ----
   // Timing
   // ----
   // Starts on a bit tick, so a part-done bit under the old setup
   // never enters the figure
   always @(posedge i_clk) begin
      o_done <= 1'b0;
      cyc <= cyc + 16'h0001;
      if (i_os)
         os <= os + 8'h01;
      if (i_clear) begin
         armed <= 1'b1;
         n <= 2'h0;
      end else if (armed && i_bit) begin
         n <= n + 2'h1;
         if (n == 2'h0) begin
            cyc <= 16'h0001;
            os <= 8'h00;
         end
         if (n == 2'h2) begin
            armed <= 1'b0;
            o_done <= 1'b1;
            o_span <= cyc;
            o_os <= os + 8'h01;
         end
      end
   end
endmodule

// file: dv/urg_rate_gen_tb_top.sv
/*
 * Testbench of the UART rate generator: register port checks and
 * two-bit period measurements for every rate source.
 * Assumes one 250 MHz clock and the partner model beside it.
 */
`timescale 1ns/1ns
module urg_rate_gen_tb_top;
   logic        i_clk = 1'b0;
   logic        i_resetn = 1'b0;
   logic [3:0]  i_addr = 4'h0;
   logic [7:0]  i_wdata = 8'h00;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [1:0]  i_uart_mode = 2'h1;
   logic        i_t1_overflow = 1'b0;
   logic        clr = 1'b0;
   logic [7:0]  o_rdata;
   logic        tx_os, rx_os, tx_bit, rx_bit, tx_done, rx_done;
   logic [15:0] tx_span, rx_span, g, d;
   logic [7:0]  tx_osn, rx_osn, r, f;
   logic [2:0]  dv;
   logic        c;
   logic [15:0] rq[$], tq[$], xq[$];
   int          error_cnt = 0;
   int          checked = 0;
   int          pend = 0;

   always #2 i_clk = ~i_clk;

   urg_rate_gen i_urg_rate_gen (.i_clk(i_clk), .i_resetn(i_resetn),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_uart_mode(i_uart_mode),
      .i_t1_overflow(i_t1_overflow), .o_tx_os_tick(tx_os),
      .o_rx_os_tick(rx_os), .o_tx_bit_tick(tx_bit),
      .o_rx_bit_tick(rx_bit));
   urg_uart_model i_tx_model (.i_clk(i_clk), .i_clear(clr),
      .i_os(tx_os), .i_bit(tx_bit), .o_done(tx_done),
      .o_span(tx_span), .o_os(tx_osn));
   urg_uart_model i_rx_model (.i_clk(i_clk), .i_clear(clr),
      .i_os(rx_os), .i_bit(rx_bit), .o_done(rx_done),
      .o_span(rx_span), .o_os(rx_osn));

   // ----
   // Helpers
   // ----
   task automatic test_done();
      if (error_cnt == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask

   // A read notes its expected byte; the watcher compares next cycle
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [7:0] v);
      i_wr <= w;
      i_rd <= ~w;
      i_addr <= a;
      i_wdata <= v;
      if (!w)
         rq.push_back({8'h00, v});
      @(posedge i_clk);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic meas(input logic [15:0] et, input logic [15:0] er);
      tq.push_back(et);
      xq.push_back(er);
      pend = 2;
      clr <= 1'b1;
      @(posedge i_clk);
      clr <= 1'b0;
      for (int k = 0; k < 10000 && pend != 0; k++)
         @(posedge i_clk);
      if (pend != 0) begin
         error_cnt++;
         test_done();
      end
   endtask

   // ----
   // Watchers and stimulus
   // ----
   always @(posedge i_clk) if (i_rd) begin
      @(negedge i_clk);
      chk({8'h00, o_rdata}, rq.pop_front());
   end

   always @(posedge i_clk) begin
      if (tx_done) begin
         chk(tx_span, tq.pop_front());
         chk({8'h00, tx_osn}, 16'h0020);
         pend--;
      end
      if (rx_done) begin
         chk(rx_span, xq.pop_front());
         chk({8'h00, rx_osn}, 16'h0020);
         pend--;
      end
   end

   always begin
      repeat (4) @(posedge i_clk);
      i_t1_overflow <= 1'b1;
      @(posedge i_clk);
      i_t1_overflow <= 1'b0;
   end

   initial begin
      repeat (60000) @(posedge i_clk);
      error_cnt++;
      test_done();
   end

   initial begin
      void'($urandom(58));
      repeat (4) @(posedge i_clk);
      i_resetn <= 1'b1;
      @(posedge i_clk);
      // Mode 1 with no select set reads legacy on both directions
      for (int a = 0; a < 11; a++)
         bus(1'b0, a[3:0], (a == 7) ? 8'h0F : 8'h00);
      f = 8'($urandom);
      bus(1'b1, 4'h1, f);
      bus(1'b0, 4'h1, f);
      bus(1'b1, 4'h0, 8'hFF);
      bus(1'b0, 4'h0, 8'h87);
      bus(1'b1, 4'hA, 8'hFF);
      bus(1'b0, 4'hA, 8'h00);
      // Stopped timer holds its reload, so it starts at full rate
      r = 8'($urandom_range(255, 192));
      g = ({8'h00, ~r} + 16'h0001) << 6;
      bus(1'b1, 4'h3, r);
      bus(1'b1, 4'h4, 8'hFF);
      bus(1'b1, 4'h0, 8'h00);
      bus(1'b1, 4'h2, 8'h14);
      i_uart_mode <= 2'h2;
      meas(16'h0080, 16'h0080);
      bus(1'b1, 4'h5, 8'h80);
      meas(16'h0040, 16'h0040);
      i_uart_mode <= 2'h3;
      bus(1'b1, 4'h1, 8'h09);
      bus(1'b1, 4'h0, 8'h81);
      bus(1'b1, 4'h2, 8'h34);
      meas(16'h0092, 16'h0092);
      bus(1'b0, 4'h7, 8'h05);
      dv = 3'($urandom_range(2, 0));
      c = 1'($urandom);
      f = 8'($urandom);
      d = (({8'h00, f} + 16'h0040) << dv) << c;
      bus(1'b1, 4'h6, {7'h00, c});
      bus(1'b1, 4'h1, f);
      bus(1'b1, 4'h0, {5'h10, dv});
      meas(d, d);
      bus(1'b1, 4'h6, 8'h00);
      bus(1'b1, 4'h2, 8'h14);
      bus(1'b1, 4'h0, 8'h00);
      i_uart_mode <= 2'h1;
      meas(g, 16'h00A0);
      bus(1'b0, 4'h7, 8'h0E);
      bus(1'b1, 4'h5, 8'h00);
      i_uart_mode <= 2'h3;
      meas(g, 16'h0140);
      bus(1'b1, 4'h2, 8'h24);
      bus(1'b0, 4'h7, 8'h0B);
      meas(16'h0140, g);
      i_uart_mode <= 2'h0;
      bus(1'b0, 4'h7, 8'h00);
      test_done();
   end
endmodule
